// *** inc/pwm_params.svh ***
// constants for the six-channel pulse-width modulator unit
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH
`define PWM_CNT_W 16
`define PWM_CHANNELS 6
`define PWM_CAPTURES 3
`define PWM_EDGES 12
`define PWM_CNT_ZERO 16'h0000
`define PWM_CNT_ONE 16'h0001
`define PWM_ST_IDLE 2'h0
`define PWM_ST_RUN 2'h1
`define PWM_ST_DONE 2'h3
`endif

// *** inc/pwm_pkg.sv ***
// types for the six-channel pulse-width modulator unit
`include "pwm_params.svh"
package pwm_pkg;
  typedef logic [`PWM_CNT_W-1:0] cnt_t;
  typedef enum logic [1:0] {
    ST_IDLE = `PWM_ST_IDLE,
    ST_RUN = `PWM_ST_RUN,
    ST_DONE = `PWM_ST_DONE
  } run_state_e;
  typedef struct packed {
    run_state_e state;
    logic running;
    cnt_t pre_cnt;
    cnt_t per_cnt;
    cnt_t pre_sh;
    cnt_t per_sh;
    logic [`PWM_CHANNELS-1:0][`PWM_CNT_W-1:0] rise_sh;
    logic [`PWM_CHANNELS-1:0][`PWM_CNT_W-1:0] fall_sh;
    logic [`PWM_CHANNELS-1:0] level;
    logic [`PWM_CHANNELS-1:0] out;
    logic xfer_pending;
    logic fault_active;
    logic [`PWM_CAPTURES-1:0] cap_prev;
    logic [`PWM_CAPTURES-1:0][`PWM_CNT_W-1:0] cap_val;
    logic [`PWM_EDGES-1:0] match_evt;
    logic [`PWM_CAPTURES-1:0] cap_evt;
    logic ovf_evt;
    logic fault_evt;
    logic irq;
    logic dly_active;
    cnt_t dly_cnt;
    logic dly_xfer;
    logic sync_out;
    logic xfer_out;
  } pwm_state_s;
endpackage

// *** core/six_channel_pwm_unit.sv ***
// six-channel pulse-width modulator unit with capture, fault hold and sync chaining
`timescale 1ns/1ps
`include "pwm_params.svh"
// Functional notes
// - six outputs, separate rise and fall positions
// - six outputs, three captures, one fault input
// - optional interrupt per matched edge
// - continuous mode or single-period run-once mode
// - period and prescale counters are 16 bits
// - period counter advances once per prescale wrap
// - fault holds outputs in software state, interrupt
// - three capture inputs and registers, optional interrupt
// - capture event latches current period count
// - interrupts for match, capture, overflow, fault
// - burst mode mixes external carrier into outputs
// - counters and control in one clock domain
// - counters on unit clock, times in clocks
// - counter clock equals bus interface clock
// - period-alignment output with programmable delay
// - units chain, each master of the next
// - alignment pulse one clock at each restart
// - shadow-load pulse only when transfer happened
// - programmable delay before both master pulses
// - slave restarts and loads on incoming pulses
module six_channel_pwm_unit
  import pwm_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,

  // run control
  input wire logic run_enable,
  input wire logic run_once,
  input wire logic slave_mode,

  // software values, loaded into shadows at restart
  input wire logic [`PWM_CNT_W-1:0] prescale_value,
  input wire logic [`PWM_CNT_W-1:0] period_value,
  input wire logic [`PWM_CHANNELS-1:0][`PWM_CNT_W-1:0] rise_pos,
  input wire logic [`PWM_CHANNELS-1:0][`PWM_CNT_W-1:0] fall_pos,
  input wire logic transfer_request,

  // output shaping
  input wire logic [`PWM_CHANNELS-1:0] burst_enable,
  input wire logic carrier_in,
  input wire logic fault_enable,
  input wire logic fault_clear,
  input wire logic [`PWM_CHANNELS-1:0] fault_state,

  // interrupt enables
  input wire logic [`PWM_EDGES-1:0] match_irq_en,
  input wire logic [`PWM_CAPTURES-1:0] capture_irq_en,
  input wire logic overflow_irq_en,
  input wire logic fault_irq_en,

  // external events
  input wire logic [`PWM_CAPTURES-1:0] edge_capture_input,
  input wire logic fault_hold_input,

  // chaining from the previous unit
  input wire logic sync_in,
  input wire logic trans_enable_in,

  // chaining to the next unit
  input wire logic [`PWM_CNT_W-1:0] sync_delay,
  output logic sync_out,
  output logic trans_enable_out,

  // waveform outputs
  output logic [`PWM_CHANNELS-1:0] modulated_output,

  // capture results and status
  output logic [`PWM_CAPTURES-1:0][`PWM_CNT_W-1:0] capture_value,
  output logic [`PWM_CNT_W-1:0] counter_value,
  output logic running,
  output logic fault_active,
  output logic transfer_pending,

  // event pulses and interrupt request
  output logic [`PWM_EDGES-1:0] match_event,
  output logic [`PWM_CAPTURES-1:0] capture_event,
  output logic overflow_event,
  output logic fault_event,
  output logic irq_request
);

  pwm_state_s cur_reg;
  pwm_state_s cur_next;

  // every field clears; the run machine parks in idle
  localparam pwm_state_s RESET_STATE = '{state: ST_IDLE, default: '0};

  // equality of the live count with one programmed edge position
  function automatic logic pos_hit(input cnt_t c, input cnt_t pos);
    pos_hit = (c == pos);
  endfunction

  // the counters only move while the run machine sits in its run state
  function automatic logic is_run(input run_state_e st);
    is_run = (st == ST_RUN);
  endfunction

  // output select per channel; a held fault outranks the carrier gate
  function automatic logic mix_out(
    input logic lvl,
    input logic carrier,
    input logic burst,
    input logic hold,
    input logic safe
  );
    if (hold) begin
      mix_out = safe;
    end else if (burst) begin
      mix_out = lvl & carrier;
    end else begin
      mix_out = lvl;
    end
  endfunction

  // counter control
  logic restart;
  logic advance;
  logic tick;
  logic wrap;
  logic do_xfer;
  logic slave_sync;
  logic pre_end;
  logic per_end;
  logic dly_end;
  cnt_t new_cnt;

  // edge compare
  logic [`PWM_CHANNELS-1:0][`PWM_CNT_W-1:0] rise_use;
  logic [`PWM_CHANNELS-1:0][`PWM_CNT_W-1:0] fall_use;
  logic [`PWM_EDGES-1:0] pos_eq;
  logic [`PWM_EDGES-1:0] hits;

  // capture, fault and interrupt terms
  logic [`PWM_CAPTURES-1:0] cap_rise;
  logic fault_set;
  logic fault_rise;
  logic irq_match;
  logic irq_cap;
  logic irq_ovf;
  logic irq_fault;

  // one comparator pair per channel; the process gates them with advance
  genvar gch;
  generate
    for (gch = 0; gch < `PWM_CHANNELS; gch = gch + 1) begin : g_cmp
      assign pos_eq[2*gch] = pos_hit(new_cnt, rise_use[gch]);
      assign pos_eq[2*gch+1] = pos_hit(new_cnt, fall_use[gch]);
    end
  endgenerate

  always_comb begin
    cur_next = cur_reg;
    restart = 1'b0;
    advance = 1'b0;
    tick = 1'b0;
    wrap = 1'b0;
    do_xfer = 1'b0;
    new_cnt = cur_reg.per_cnt;
    hits = '0;
    // terminal counts, decoded once
    slave_sync = slave_mode & sync_in;
    pre_end = (cur_reg.pre_cnt == cur_reg.pre_sh);
    per_end = (cur_reg.per_cnt == cur_reg.per_sh);
    dly_end = (cur_reg.dly_cnt == `PWM_CNT_ONE);

    // run state machine
    case (cur_reg.state)
      ST_IDLE: begin
        if (run_enable) begin
          cur_next.state = ST_RUN;
          restart = 1'b1;
        end
      end
      ST_RUN: begin
        if (!run_enable) begin
          cur_next.state = ST_IDLE;
        end
      end
      ST_DONE: begin
        if (!run_enable) begin
          cur_next.state = ST_IDLE;
        end
      end
      default: begin
        cur_next.state = ST_IDLE;
      end
    endcase

    // prescaler and period counter
    if (is_run(cur_reg.state) && run_enable) begin
      if (slave_sync) begin
        restart = 1'b1;
      end else if (pre_end) begin
        tick = 1'b1;
        if (per_end) begin
          wrap = 1'b1;
          if (run_once) begin
            cur_next.state = ST_DONE;
          end else begin
            restart = 1'b1;
          end
        end
      end
    end

    if (restart) begin
      cur_next.pre_cnt = `PWM_CNT_ZERO;
      new_cnt = `PWM_CNT_ZERO;
      advance = 1'b1;
    end else if (tick && !wrap) begin
      cur_next.pre_cnt = `PWM_CNT_ZERO;
      new_cnt = cur_reg.per_cnt + `PWM_CNT_ONE;
      advance = 1'b1;
    end else if (wrap) begin
      cur_next.pre_cnt = `PWM_CNT_ZERO;
      new_cnt = `PWM_CNT_ZERO;
    end else if (is_run(cur_reg.state)) begin
      cur_next.pre_cnt = cur_reg.pre_cnt + `PWM_CNT_ONE;
    end
    cur_next.per_cnt = new_cnt;
    cur_next.ovf_evt = wrap;
    // status bit kept in a flop so the port has no decode behind it
    cur_next.running = is_run(cur_next.state);

    // shadow load only at restart; slaves follow the master's indication
    if (restart) begin
      do_xfer = slave_mode ? trans_enable_in : cur_reg.xfer_pending;
    end
    if (do_xfer) begin
      cur_next.pre_sh = prescale_value;
      cur_next.per_sh = period_value;
      cur_next.rise_sh = rise_pos;
      cur_next.fall_sh = fall_pos;
    end
    // a request in the transfer cycle survives: set wins over clear
    cur_next.xfer_pending = transfer_request | (cur_reg.xfer_pending & ~do_xfer);
    rise_use = do_xfer ? rise_pos : cur_reg.rise_sh;
    fall_use = do_xfer ? fall_pos : cur_reg.fall_sh;

    // edge compare per channel
    if (advance) begin
      hits = pos_eq;
    end
    for (int ch = 0; ch < `PWM_CHANNELS; ch++) begin
      if (hits[2*ch]) begin
        cur_next.level[ch] = 1'b1;
      end
      // falling edge wins when both positions coincide
      if (hits[2*ch+1]) begin
        cur_next.level[ch] = 1'b0;
      end
    end
    cur_next.match_evt = hits;

    // fault hold, set wins over clear
    fault_set = fault_enable & fault_hold_input;
    fault_rise = fault_set & ~cur_reg.fault_active;
    cur_next.fault_active = fault_set | (cur_reg.fault_active & ~fault_clear);
    cur_next.fault_evt = fault_rise;

    // output mixing: fault overrides burst, burst gates the waveform
    for (int ch = 0; ch < `PWM_CHANNELS; ch++) begin
      cur_next.out[ch] = mix_out(cur_next.level[ch], carrier_in, burst_enable[ch],
        cur_next.fault_active, fault_state[ch]);
    end

    // capture on rising edge of each input
    cap_rise = edge_capture_input & ~cur_reg.cap_prev;
    cur_next.cap_prev = edge_capture_input;
    for (int k = 0; k < `PWM_CAPTURES; k++) begin
      if (cap_rise[k]) begin
        cur_next.cap_val[k] = cur_reg.per_cnt;
      end
    end
    cur_next.cap_evt = cap_rise;

    // masked events onto one request
    irq_match = |(hits & match_irq_en);
    irq_cap = |(cap_rise & capture_irq_en);
    irq_ovf = wrap & overflow_irq_en;
    irq_fault = fault_rise & fault_irq_en;
    cur_next.irq = irq_match | irq_cap | irq_ovf | irq_fault;

    // delayed alignment and shadow-load pulses; a new restart re-arms the delay
    cur_next.sync_out = 1'b0;
    cur_next.xfer_out = 1'b0;
    if (restart) begin
      if (sync_delay == `PWM_CNT_ZERO) begin
        cur_next.sync_out = 1'b1;
        cur_next.xfer_out = do_xfer;
        cur_next.dly_active = 1'b0;
      end else begin
        cur_next.dly_active = 1'b1;
        cur_next.dly_cnt = sync_delay;
        cur_next.dly_xfer = do_xfer;
      end
    end else if (cur_reg.dly_active) begin
      if (dly_end) begin
        cur_next.dly_active = 1'b0;
        cur_next.sync_out = 1'b1;
        cur_next.xfer_out = cur_reg.dly_xfer;
      end else begin
        cur_next.dly_cnt = cur_reg.dly_cnt - `PWM_CNT_ONE;
      end
    end
  end

  // single clock: counters and control share the unit clock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_reg <= RESET_STATE;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // chain pulses
  assign sync_out = cur_reg.sync_out;
  assign trans_enable_out = cur_reg.xfer_out;

  // waveform, capture and status levels
  assign modulated_output = cur_reg.out;
  assign capture_value = cur_reg.cap_val;
  assign counter_value = cur_reg.per_cnt;
  assign running = cur_reg.running;
  assign fault_active = cur_reg.fault_active;
  assign transfer_pending = cur_reg.xfer_pending;

  // one-cycle events; irq is not sticky
  assign match_event = cur_reg.match_evt;
  assign capture_event = cur_reg.cap_evt;
  assign overflow_event = cur_reg.ovf_evt;
  assign fault_event = cur_reg.fault_evt;
  assign irq_request = cur_reg.irq;

endmodule // six_channel_pwm_unit

// *** tb/pwm_sva.sv ***
// assertion checker for the six-channel modulator unit
`timescale 1ns/1ps
`include "pwm_params.svh"
module pwm_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // watched inputs
  input wire logic run_enable,
  input wire logic transfer_request,
  input wire logic fault_enable,
  input wire logic fault_hold_input,
  input wire logic [`PWM_CHANNELS-1:0] fault_state,
  input wire logic [`PWM_CAPTURES-1:0] edge_capture_input,
  input wire logic overflow_irq_en,
  input wire logic [`PWM_CNT_W-1:0] sync_delay,
  // watched outputs
  input wire logic sync_out,
  input wire logic trans_enable_out,
  input wire logic [`PWM_CHANNELS-1:0] modulated_output,
  input wire logic [`PWM_CAPTURES-1:0][`PWM_CNT_W-1:0] capture_value,
  input wire logic [`PWM_CNT_W-1:0] counter_value,
  input wire logic running,
  input wire logic fault_active,
  input wire logic transfer_pending,
  input wire logic [`PWM_EDGES-1:0] match_event,
  input wire logic [`PWM_CAPTURES-1:0] capture_event,
  input wire logic overflow_event,
  input wire logic fault_event,
  input wire logic irq_request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // capture is two steps: input edge, then stored count
  sequence s_cap_rise; $rose(edge_capture_input[0]); endsequence
  sequence s_cap_done; capture_event[0] && capture_value[0] == $past(counter_value); endsequence
  property p_cap; s_cap_rise |=> s_cap_done; endproperty
  property p_xfer; trans_enable_out |-> sync_out; endproperty
  property p_ovf; overflow_event |-> counter_value == 16'h0000; endproperty
  property p_ovf_sync;
    overflow_event && running && sync_delay == 16'h0000
      && $past(sync_delay) == 16'h0000 |-> sync_out;
  endproperty
  property p_fault; fault_enable && fault_hold_input |=> fault_active && modulated_output == $past(fault_state); endproperty
  property p_fault_evt; $rose(fault_active) |-> fault_event; endproperty
  property p_run; $rose(run_enable) && !running |=> running; endproperty
  property p_stop; !run_enable |=> !running; endproperty
  property p_pend; transfer_request |=> transfer_pending; endproperty
  property p_irq; !(|match_event) && !(|capture_event) && !overflow_event && !fault_event |-> !irq_request; endproperty
  property p_ovf_irq; overflow_event && $past(overflow_irq_en) |-> irq_request; endproperty
  a_cap: assert property (p_cap) else $error("capture value wrong");
  a_xfer: assert property (p_xfer) else $error("load mark without sync");
  a_ovf: assert property (p_ovf) else $error("wrap not to zero");
  a_ovf_sync: assert property (p_ovf_sync) else $error("no sync at restart");
  a_fault: assert property (p_fault) else $error("fault hold wrong");
  a_fault_evt: assert property (p_fault_evt) else $error("no fault event");
  a_run: assert property (p_run) else $error("start missed");
  a_stop: assert property (p_stop) else $error("stop missed");
  a_pend: assert property (p_pend) else $error("pending not set");
  a_irq: assert property (p_irq) else $error("stray irq");
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missed");
endmodule // pwm_sva
bind six_channel_pwm_unit pwm_sva u_sva (.*);

// *** tb/pwm_master_model.sv ***
// upstream master unit model: sync pulses, load marks and carrier
`timescale 1ns/1ps
module pwm_master_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic active,
  // chain outputs
  output logic sync_pulse,
  output logic xfer_pulse,
  output logic carrier
);
  logic [2:0] cnt_reg;
  logic [1:0] car_reg;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 3'h0;
      car_reg <= 2'h0;
      sync_pulse <= 1'b0;
      xfer_pulse <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == 3'h5) ? 3'h0 : cnt_reg + 3'h1;
      car_reg <= car_reg + 2'h1;
      // one-clock pulses, master drives both lines
      sync_pulse <= active && cnt_reg == 3'h5;
      xfer_pulse <= active && cnt_reg == 3'h5;
    end
  end
  assign carrier = car_reg[1];
endmodule // pwm_master_model

// *** tb/testbench.sv ***
// self-checking testbench for the six-channel modulator unit
`timescale 1ns/1ps
module testbench;
  logic ref_clk, rst, run_enable, run_once, slave_mode, transfer_request, carrier_in, car_on, mcar;
  logic fault_enable, fault_clear, overflow_irq_en, fault_irq_en, fault_hold_input, sync_in;
  logic trans_enable_in, sync_out, trans_enable_out, running, fault_active, transfer_pending;
  logic overflow_event, fault_event, irq_request;
  logic [15:0] prescale_value, period_value, sync_delay, counter_value;
  logic [5:0] burst_enable, fault_state, modulated_output, eo;
  logic [5:0][15:0] rise_pos, fall_pos;
  logic [11:0] match_irq_en, match_event, em;
  logic [2:0] capture_irq_en, edge_capture_input, capture_event;
  logic [2:0][15:0] capture_value;
  int err_count, n_compared, i, c, n;
  six_channel_pwm_unit dut (.*);
  pwm_master_model up (.ref_clk(ref_clk), .rst(rst), .active(slave_mode),
    .sync_pulse(sync_in), .xfer_pulse(trans_enable_in), .carrier(mcar));
  assign carrier_in = mcar & car_on;
  always #12.5 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // the watchdog bounds every wait below
  task automatic wait_ovf;
    do @(negedge ref_clk); while (overflow_event !== 1'b1);
  endtask
  task automatic load(input logic [15:0] ps, input logic [15:0] per);
    @(posedge ref_clk);
    prescale_value <= ps;
    period_value <= per;
    transfer_request <= 1'b1;
    @(posedge ref_clk);
    transfer_request <= 1'b0;
    @(negedge ref_clk);
    chk("pending", 16'h0001, 16'(transfer_pending));
    wait_ovf();
    wait_ovf();
  endtask
  initial begin
    #500000;
    err_count++;
    final_report();
  end
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    {run_enable, run_once, slave_mode, transfer_request, fault_enable, fault_clear} = '0;
    {fault_hold_input, car_on, edge_capture_input, burst_enable, fault_state} = '0;
    {prescale_value, period_value, sync_delay} = '0;
    {overflow_irq_en, fault_irq_en, match_irq_en, capture_irq_en} = '1;
    for (c = 0; c < 6; c++) begin
      rise_pos[c] = 16'(c + 1);
      fall_pos[c] = 16'(c + 4);
    end
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    run_enable <= 1'b1;
    // period length is (period+1)*(prescale+1) clocks
    for (i = 0; i < 3; i++) begin
      load(16'(i), 16'(2 + i));
      n = 0;
      do begin @(negedge ref_clk); n++; end while (overflow_event !== 1'b1);
      chk("period", 16'((i + 1) * (i + 3)), 16'(n));
    end
    load(16'h0000, 16'h0009);
    for (i = 0; i < 10; i++) begin
      for (c = 0; c < 6; c++) begin
        eo[c] = i > c && i < c + 4;
        em[2 * c] = i == c + 1;
        em[2 * c + 1] = i == c + 4;
      end
      chk("count", 16'(i), counter_value);
      chk("out", 16'(eo), 16'(modulated_output));
      chk("match", 16'(em), 16'(match_event));
      @(negedge ref_clk);
    end
    // back-to-back captures at counts 1, 2 and 3
    wait_ovf();
    for (i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      edge_capture_input <= (i < 3) ? 3'((2 << i) - 1) : 3'h0;
    end
    @(negedge ref_clk);
    for (i = 0; i < 3; i++) chk("capture", 16'(i + 1), capture_value[i]);
    // carrier held low must blank every burst channel
    burst_enable <= 6'h3F;
    wait_ovf();
    wait_ovf();
    for (i = 0; i < 10; i++) begin
      chk("burst", 16'h0000, 16'(modulated_output));
      @(negedge ref_clk);
    end
    burst_enable <= 6'h05;
    car_on <= 1'b1;
    @(posedge ref_clk);
    fault_state <= 6'h2A;
    fault_enable <= 1'b1;
    fault_hold_input <= 1'b1;
    @(posedge ref_clk);
    fault_hold_input <= 1'b0;
    repeat (12) @(negedge ref_clk);
    chk("fault", 16'h002A, 16'(modulated_output));
    @(posedge ref_clk);
    fault_clear <= 1'b1;
    @(posedge ref_clk);
    fault_clear <= 1'b0;
    @(negedge ref_clk);
    chk("fault_clr", 16'h0000, 16'(fault_active));
    sync_delay <= 16'h0003;
    wait_ovf();
    wait_ovf();
    n = 0;
    do begin @(negedge ref_clk); n++; end while (sync_out !== 1'b1);
    chk("sync_dly", 16'h0003, 16'(n));
    sync_delay <= 16'h0000;
    slave_mode <= 1'b1;
    for (i = 0; i < 3; i++) begin
      do @(negedge ref_clk); while (sync_in !== 1'b1);
      @(negedge ref_clk);
      chk("slave", 16'h0000, counter_value);
    end
    slave_mode <= 1'b0;
    run_once <= 1'b1;
    wait_ovf();
    repeat (3) @(negedge ref_clk);
    chk("once_run", 16'h0000, 16'(running));
    chk("once_cnt", 16'h0000, counter_value);
    @(posedge ref_clk);
    run_enable <= 1'b0;
    @(posedge ref_clk);
    run_enable <= 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("restart", 16'h0001, 16'(running));
    final_report();
  end
endmodule // testbench
